// *** shared/vid_ctrl_pkg.sv ***
// constants, states and register map of the voltage-code control slice
// How it works
// RULE1 - serial voltage-code link is served only while system power good is high
// RULE2 - a valid command moves every selected rail, both together when both are selected
// RULE3 - power good falling drives telemetry high and sends every rail back to boot code
// RULE4 - boot code is stored right after enable and serves as fallback target
// RULE5 - while power good is low, serial clock and data are ignored, nothing decoded
// RULE6 - on power good return, wait for a new command before changing targets
// RULE7 - power good must rise after enable; otherwise no soft-start happens
// RULE8 - upward change steps the reference at 12.5 mV per microsecond
// RULE9 - downward change steps the reference at 12.5 mV per microsecond
// RULE10 - a rail is forced to continuous conduction while its code change runs
// RULE11 - a rail's power-saving mode comes back when the change finishes
// RULE12 - both rail good outputs stay high through a code change
// RULE13 - at change end, check protections, then report completion on the link
// RULE14 - the off code steps the rail down to zero with rail good kept high
// RULE15 - each rail starts in continuous conduction before any power-state command
// RULE16 - power-state bits 00 and 10 give diode emulation, 01 and 11 continuous
// RULE17 - power-state bit zero high returns a rail to continuous conduction
// RULE18 - the two configuration pins are sampled once after power up and held
// RULE19 - first pin: current limit, compensation bit 1, ramp; second: delay, bit 0, others
// RULE20 - the master opens each packet with 11000 then core and northbridge selectors
// RULE21 - boot code is latched from serial clock and data at enable rising edge
// RULE22 - a new command during stepping retargets the rail at the same slew
package vid_ctrl_pkg;
  localparam int CLK_MHZ        = 100;
  localparam int STEP_UV        = 6250;
  localparam int SLEW_UV_PER_US = 12500;
  localparam int SOFT_UV_PER_US = 3000;
  localparam int ON_THE_FLY_CODE_CHANGE_CYCLES    = (STEP_UV * CLK_MHZ) / SLEW_UV_PER_US;
  localparam int SOFT_CYCLES    = (STEP_UV * CLK_MHZ + SOFT_UV_PER_US - 1) / SOFT_UV_PER_US;
  localparam logic [7:0] TICK_ON_THE_FLY_CODE_CHANGE = 8'(ON_THE_FLY_CODE_CHANGE_CYCLES - 1);
  localparam logic [7:0] TICK_SOFT = 8'(SOFT_CYCLES - 1);

  localparam logic [7:0] TOP_LEVEL  = 8'hF8;
  localparam logic [7:0] BOOT_LVL00 = 8'hB0;
  localparam logic [7:0] BOOT_LVL01 = 8'hA0;
  localparam logic [7:0] BOOT_LVL10 = 8'h90;
  localparam logic [7:0] BOOT_LVL11 = 8'h80;

  localparam logic [4:0] PKT_HEADER = 5'h18;
  localparam logic [4:0] PKT_BITS   = 5'h1B;

  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_LEVEL  = 4'h8;
  localparam logic [3:0]  OFS_CONFIG = 4'hC;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_SOFT = 2'b01,
    ST_RUN  = 2'b11,
    ST_DOWN = 2'b10
  } pwr_state_e;
endpackage

// *** rtl/vid_mode_control.sv ***
// serial voltage-code receiver, rail reference stepping and mode control
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module vid_mode_control
  import vid_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // platform pins
  input  wire logic        enable_in,
  input  wire logic        system_power_good_in,
  input  wire logic [1:0]  protection_fault_in,
  // serial link
  input  wire logic        svc_in,
  input  wire logic        svd_in,
  output logic             telemetry_out,
  output logic             telemetry_oe,
  // configuration pin converter results
  input  wire logic        config_valid_in,
  input  wire logic [3:0]  config_pin_first_in,
  input  wire logic [3:0]  config_pin_second_in,
  // rail outputs, index 0 core, 1 northbridge
  output logic [7:0]       core_ref_level,
  output logic [7:0]       northbridge_ref_level,
  output logic [1:0]       continuous_conduction,
  output logic             core_rail_good_out,
  output logic             nb_rail_good_out,
  output logic [3:0]       config_pin_first,
  output logic [3:0]       config_pin_second,
  output logic [1:0]       transition_compensation
);

  localparam int SW = 15;

  logic [SW-1:0] async_in;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic          en_d;
  logic          pg_d;
  logic          svc_d;
  logic          svd_d;
  pwr_state_e    state;
  logic          seq_error;
  logic [1:0]    boot_sel;
  logic [7:0]    boot_level;
  logic [7:0]    tick_cnt;
  logic          tick;
  logic          in_pkt;
  logic [4:0]    bit_cnt;
  logic [26:0]   sr;
  logic          cmd_valid;
  logic [7:0]    cmd_level;
  logic [7:0]    level [2];
  logic [7:0]    target [2];
  logic [1:0]    busy;
  logic [1:0]    diode_emulation;
  logic [1:0]    good;
  logic [1:0]    done;
  logic          cpl_pend;
  logic          tele_lo;
  logic          cfg_done;
  logic [31:0]   ctrl;
  logic          aw_hold;
  logic          w_hold;
  logic [3:0]    aw_addr;
  logic [31:0]   w_data;
  logic          w_strb0;
  logic [31:0]   rd_mux;

  wire en  = sync2[0];
  wire pg  = sync2[1];
  wire svc = sync2[2];
  wire svd = sync2[3];
  wire [1:0] fault   = sync2[5:4];
  wire cfg_valid     = sync2[6];
  wire en_rise       = en & ~en_d;
  wire svi_active    = (state == ST_RUN) & pg;
  wire pg_fall       = (state == ST_RUN) & pg_d & ~pg;
  wire svc_rise      = svc & ~svc_d;
  wire pkt_start     = svc & svc_d & svd_d & ~svd;
  wire pkt_stop      = svc & svc_d & ~svd_d & svd;
  wire levels_boot   = (level[0] == boot_level) & (level[1] == boot_level);
  wire levels_zero   = (level[0] == 8'h00) & (level[1] == 8'h00);

  assign async_in = {config_pin_second_in, config_pin_first_in, config_valid_in,
                     protection_fault_in, svd_in, svc_in, system_power_good_in, enable_in};

  // two-stage synchroniser for every pin
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_d  <= 1'b0;
      pg_d  <= 1'b0;
      svc_d <= 1'b0;
      svd_d <= 1'b0;
    end else begin
      en_d  <= en;
      pg_d  <= pg;
      svc_d <= svc;
      svd_d <= svd;
    end
  end

  // boot code from the clock and data pin levels
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boot_sel <= 2'h0;
    end else if (en_rise && state == ST_OFF) begin
      boot_sel <= {svc, svd}; // RULE21 RULE4
    end
  end

  always_comb begin
    unique case (boot_sel)
      2'b00: boot_level = BOOT_LVL00;
      2'b01: boot_level = BOOT_LVL01;
      2'b10: boot_level = BOOT_LVL10;
      2'b11: boot_level = BOOT_LVL11;
    endcase
  end

  // power sequence
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_OFF;
      seq_error <= 1'b0;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (en_rise) begin
            if (pg) begin
              seq_error <= 1'b1; // RULE7
            end else begin
              seq_error <= 1'b0;
              state     <= ST_SOFT;
            end
          end
        end
        ST_SOFT: begin
          if (!en) begin
            state <= ST_DOWN;
          end else if (levels_boot) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en) begin
            state <= ST_DOWN;
          end
        end
        ST_DOWN: begin
          if (levels_zero) begin
            state <= ST_OFF;
          end
        end
      endcase
    end
  end

  // step timebase: slew rate in run, soft-start rate otherwise
  assign tick = (tick_cnt == 8'h00);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= TICK_SOFT;
    end else if (tick) begin
      tick_cnt <= (state == ST_RUN) ? TICK_ON_THE_FLY_CODE_CHANGE : TICK_SOFT; // RULE8 RULE9
    end else begin
      tick_cnt <= tick_cnt - 8'h01;
    end
  end

  // packet receiver
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      in_pkt  <= 1'b0;
      bit_cnt <= 5'h00;
      sr      <= '0;
    end else if (!svi_active) begin
      in_pkt  <= 1'b0; // RULE5
      bit_cnt <= 5'h00;
    end else if (pkt_start) begin
      in_pkt  <= 1'b1;
      bit_cnt <= 5'h00;
    end else if (pkt_stop) begin
      in_pkt  <= 1'b0;
    end else if (in_pkt && svc_rise && bit_cnt != 5'h1F) begin
      sr      <= {sr[25:0], svd};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // header 11000 in bit times 1..5, bit time 8 always zero
  assign cmd_valid = svi_active & pkt_stop & in_pkt & (bit_cnt == PKT_BITS)
                   & (sr[26:22] == PKT_HEADER) & ~sr[19]; // RULE1 RULE20

  // code counts down in voltage; codes at the top are off
  wire [7:0] vid_code = {sr[16:10], sr[8]};
  assign cmd_level = (vid_code >= TOP_LEVEL) ? 8'h00 : TOP_LEVEL - vid_code; // RULE14

  for (genvar r = 0; r < 2; r++) begin : g_rail
    wire sel = (r == 0) ? sr[21] : sr[20];

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        level[r]  <= 8'h00;
        target[r] <= 8'h00;
        busy[r]   <= 1'b0;
        diode_emulation[r]    <= 1'b0; // RULE15
        done[r]   <= 1'b0;
      end else begin
        done[r] <= 1'b0;
        if (state == ST_SOFT) begin
          target[r] <= boot_level;
        end else if (state == ST_DOWN || state == ST_OFF) begin
          target[r] <= 8'h00;
          busy[r]   <= 1'b0;
          diode_emulation[r]    <= 1'b0;
        end else if (pg_fall) begin
          target[r] <= boot_level; // RULE3
          busy[r]   <= 1'b1;
          diode_emulation[r]    <= 1'b0;
        end else if (cmd_valid && sel) begin
          target[r] <= cmd_level; // RULE2 RULE22 RULE6
          busy[r]   <= 1'b1;
          diode_emulation[r]    <= ~sr[17]; // RULE16 RULE17
        end else if (busy[r] && level[r] == target[r]) begin
          busy[r] <= 1'b0;
          done[r] <= 1'b1;
        end
        if (tick && level[r] < target[r]) begin
          level[r] <= level[r] + 8'h01; // RULE8
        end else if (tick && level[r] > target[r]) begin
          level[r] <= level[r] - 8'h01; // RULE9
        end
      end
    end

    // forced continuous while stepping, saved mode afterwards
    assign continuous_conduction[r] = ~diode_emulation[r] | busy[r] | (state != ST_RUN); // RULE10 RULE11

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        good[r] <= 1'b0;
      end else if (state != ST_RUN) begin
        good[r] <= (state == ST_SOFT) & levels_boot & en;
      end else if (done[r] && fault[r] && ctrl[0]) begin
        good[r] <= 1'b0; // RULE13
      end
    end
  end

  assign core_ref_level        = level[0];
  assign northbridge_ref_level = level[1];
  assign core_rail_good_out    = good[0]; // RULE12
  assign nb_rail_good_out      = good[1];

  // completion report: one low bit on telemetry
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpl_pend <= 1'b0;
      tele_lo  <= 1'b0;
    end else begin
      if (|done && svi_active) begin
        cpl_pend <= 1'b1; // RULE13
      end else if (!svi_active || (cpl_pend && svc_rise && !in_pkt)) begin
        cpl_pend <= 1'b0;
      end
      if (!svi_active) begin
        tele_lo <= 1'b0;
      end else if (svc_rise) begin
        tele_lo <= cpl_pend & ~in_pkt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      telemetry_out <= 1'b1;
      telemetry_oe  <= 1'b0;
    end else begin
      telemetry_out <= ~(svi_active & tele_lo); // RULE3
      telemetry_oe  <= (state != ST_OFF) | en;
    end
  end

  // configuration pins captured once
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_done          <= 1'b0;
      config_pin_first  <= 4'h0;
      config_pin_second <= 4'h0;
    end else if (cfg_valid && !cfg_done) begin
      cfg_done          <= 1'b1; // RULE18
      config_pin_first  <= sync2[10:7];
      config_pin_second <= sync2[14:11];
    end
  end

  assign transition_compensation = {config_pin_first[0], config_pin_second[0]}; // RULE19

  // axi4-lite write path
  assign s_axi_awready = ~aw_hold;
  assign s_axi_wready  = ~w_hold;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= '0;
      w_strb0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold) begin
        w_hold  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end else if (aw_hold && w_hold && !s_axi_bvalid) begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl        <= CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_hold && w_hold && !s_axi_bvalid) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == OFS_CTRL) begin
        ctrl[0]     <= w_strb0 ? w_data[0] : ctrl[0];
        s_axi_bresp <= RESP_OKAY;
      end else if (aw_addr == OFS_STATUS || aw_addr == OFS_LEVEL
                   || aw_addr == OFS_CONFIG) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read path
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    unique case (s_axi_araddr)
      OFS_CTRL:   rd_mux = {31'h0, ctrl[0]};
      OFS_STATUS: rd_mux = {19'h0, cfg_done, seq_error, cpl_pend, diode_emulation, good,
                            continuous_conduction, busy, state};
      OFS_LEVEL:  rd_mux = {target[1], target[0], level[1], level[0]};
      OFS_CONFIG: rd_mux = {24'h0, config_pin_second, config_pin_first};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_core_cmd;
    cmd_valid && sr[21];
  endsequence

  sequence s_core_ccm_busy;
    busy[0] && continuous_conduction[0];
  endsequence

  a_link_gated: assert property (!svi_active |-> !cmd_valid) // RULE5
    else $error("command decoded while link disabled");
  a_fallback_boot: assert property (pg_fall |=> target[0] == boot_level
                                    && target[1] == boot_level && telemetry_out) // RULE3
    else $error("power good loss did not return to boot");
  a_boot_latch: assert property (en_rise && state == ST_OFF |=> boot_sel == $past({svc, svd})) // RULE21
    else $error("boot code not latched at enable rise");
  a_seq_block: assert property (state == ST_OFF && en_rise && pg |=> state == ST_OFF) // RULE7
    else $error("soft-start despite wrong order");
  a_slew_tick: assert property (state == ST_RUN && $past(state) == ST_RUN
                                && level[0] != $past(level[0]) |-> $past(tick)) // RULE8
    else $error("reference stepped without tick");
  a_tick_spacing: assert property (state == ST_RUN && tick |=> !tick [*8]) // RULE9
    else $error("slew ticks too close");
  a_ccm_forced: assert property (s_core_cmd |=> s_core_ccm_busy) // RULE10
    else $error("rail not forced continuous during change");
  a_psi_decode: assert property ((s_core_cmd and !pg_fall) |=> diode_emulation[0] == !$past(sr[17])) // RULE16
    else $error("power-state decode wrong");
  a_cmd_target: assert property ((s_core_cmd and !pg_fall) |=> target[0] == $past(cmd_level)) // RULE2
    else $error("target not taken from command");
  a_good_hold: assert property (busy[0] && good[0] && state == ST_RUN && !done[0]
                                |=> good[0]) // RULE12
    else $error("rail good dropped during change");
  a_done_report: assert property (done[0] && svi_active |=> cpl_pend) // RULE13
    else $error("completion not reported");
  a_cfg_hold: assert property (cfg_done |=> $stable(config_pin_first)
                               && $stable(config_pin_second)) // RULE18
    else $error("configuration changed after capture");

endmodule

// *** dv/svi_master_model.sv ***
// serial voltage-code master model: packets, free clocks and boot pin levels
`timescale 1ns/1ps
module svi_master_model (
  // clock
  input  wire logic sys_clk,
  // serial link
  output logic      svc_in,
  output logic      svd_in,
  input  wire logic telemetry_out,
  input  wire logic telemetry_oe
);
  int tel_low = 0;

  initial begin
    svc_in = 1'b1;
    svd_in = 1'b1;
  end

  // half of an 80 ns link clock period
  task automatic half();
    repeat (4) @(posedge sys_clk);
  endtask

  // boot code levels, held across the enable rising edge
  task automatic pins(input logic [1:0] v);
    @(posedge sys_clk);
    {svc_in, svd_in} <= v;
  endtask

  task automatic bit_out(input logic b);
    svc_in <= 1'b0;
    svd_in <= b;
    half();
    svc_in <= 1'b1;
    half();
  endtask

  // one packet: start, 27 bit times, stop; link clock rests high outside
  task automatic send(input logic core, nb, input logic [7:0] vid, input logic p0, p1);
    logic [26:0] pkt;
    // last bit time low, so the stop is a plain rise of data
    pkt = {5'b11000, core, nb, 1'b0, 1'b1, p0, vid[7:1], 1'b1, vid[0], p1, 7'h00};
    @(posedge sys_clk);
    svd_in <= 1'b0;
    half();
    for (int i = 26; i >= 0; i--) bit_out(pkt[i]);
    // stop: data rises while the link clock rests high, no extra clock edge
    svd_in <= 1'b1;
    half();
  endtask

  // clock cycles outside a packet, giving the device room to report
  task automatic idle(input int n);
    @(posedge sys_clk);
    repeat (n) begin
      svc_in <= 1'b0;
      half();
      svc_in <= 1'b1;
      half();
    end
  endtask

  always @(posedge sys_clk) begin
    if (telemetry_oe === 1'b1 && telemetry_out === 1'b0) tel_low <= tel_low + 1;
  end
endmodule

// *** dv/svi2_vid_mode_control_bench.sv ***
// self-checking testbench of the voltage-code mode control slice
`timescale 1ns/1ps
module svi2_vid_mode_control_bench
  import vid_ctrl_pkg::*;
;
  logic        sys_clk, resetn, enable_in, system_power_good_in, config_valid_in, watch;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [3:0]  config_pin_first_in, config_pin_second_in, config_pin_first, config_pin_second;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, svc_in, svd_in, telemetry_out, telemetry_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, protection_fault_in, continuous_conduction, rs;
  logic [1:0]  transition_compensation;
  logic        core_rail_good_out, nb_rail_good_out;
  logic [7:0]  core_ref_level, northbridge_ref_level;
  int          fails = 0, checks_done = 0, cycles = 0, drops = 0, g, t0;

  vid_mode_control u_dut (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .enable_in, .system_power_good_in, .protection_fault_in, .svc_in, .svd_in,
    .telemetry_out, .telemetry_oe, .config_valid_in, .config_pin_first_in,
    .config_pin_second_in, .core_ref_level, .northbridge_ref_level, .continuous_conduction,
    .core_rail_good_out, .nb_rail_good_out, .config_pin_first, .config_pin_second,
    .transition_compensation
  );

  svi_master_model u_host (.sys_clk, .svc_in, .svd_in, .telemetry_out, .telemetry_oe);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // packet addressed by reference level rather than raw code
  task automatic go(input logic c, n, input logic [7:0] lvl, input logic p0, p1);
    u_host.send(c, n, 8'hF8 - lvl, p0, p1);
  endtask

  task automatic until_change(output int n);
    logic [7:0] v;
    v = core_ref_level;
    n = 0;
    while (core_ref_level === v && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // cycles between two consecutive core reference steps
  task automatic step_gap(output int gap);
    until_change(gap);
    until_change(gap);
  endtask

  task automatic wait_lvl(input logic [7:0] c, n, input int lim);
    int k;
    k = 0;
    while (!(core_ref_level === c && northbridge_ref_level === n) && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (watch && {core_rail_good_out, nb_rail_good_out} !== 2'b11) drops++;
    if (cycles == 100000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {resetn, enable_in, system_power_good_in, config_valid_in, watch} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {config_pin_first_in, config_pin_second_in} = '0;
    s_axi_wstrb = 4'hF;
    protection_fault_in = 2'b00;
    tick(3);
    resetn <= 1'b1;
    tick(1);
    chk("ccm", continuous_conduction, 2'b11);
    chk("level", {core_ref_level, northbridge_ref_level}, 16'h0000);
    axi_rd(OFS_CTRL, rd, rs);
    chk("ctrl", rd, CTRL_RESET);
    axi_wr(OFS_CTRL, 32'h0, rs);
    chk("bresp", rs, RESP_OKAY);
    axi_rd(OFS_CTRL, rd, rs);
    chk("ctrl", rd, 32'h0);
    axi_wr(OFS_CTRL, CTRL_RESET, rs);
    axi_rd(4'h2, rd, rs);
    chk("rresp", rs, RESP_SLVERR);
    // power good before enable: no start-up
    system_power_good_in <= 1'b1;
    tick(5);
    enable_in <= 1'b1;
    tick(400);
    axi_rd(OFS_STATUS, rd, rs);
    chk("seq_err", {rd[11], rd[1:0]}, 3'b100);
    chk("no_start", core_ref_level, 8'h00);
    resetn <= 1'b0;
    enable_in <= 1'b0;
    system_power_good_in <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    config_pin_first_in <= 4'hA;
    config_pin_second_in <= 4'h5;
    config_valid_in <= 1'b1;
    tick(8);
    config_valid_in <= 1'b0;
    config_pin_first_in <= 4'h3;
    tick(2);
    config_valid_in <= 1'b1;
    tick(8);
    chk("cfg", {config_pin_first, config_pin_second, transition_compensation}, 10'h295);
    u_host.pins(2'b10);
    tick(5);
    enable_in <= 1'b1;
    tick(10);
    u_host.pins(2'b11);
    wait_lvl(8'h90, 8'h90, 32000);
    tick(50);
    chk("boot", {core_ref_level, northbridge_ref_level}, 16'h9090);
    chk("good", {core_rail_good_out, nb_rail_good_out}, 2'b11);
    system_power_good_in <= 1'b1;
    tick(10);
    watch = 1'b1;
    go(1'b1, 1'b1, 8'h94, 1'b0, 1'b1);
    step_gap(g);
    chk("slew_up", g, 50);
    chk("both", northbridge_ref_level, core_ref_level);
    chk("ccm_on_the_fly_code_change", continuous_conduction, 2'b11);
    wait_lvl(8'h94, 8'h94, 1000);
    tick(5);
    chk("dem_back", continuous_conduction, 2'b00);
    t0 = u_host.tel_low;
    u_host.idle(3);
    chk("report", u_host.tel_low - t0, 8);
    go(1'b1, 1'b0, 8'h8C, 1'b1, 1'b0);
    step_gap(g);
    chk("slew_dn", g, 50);
    wait_lvl(8'h8C, 8'h94, 1000);
    tick(5);
    chk("ccm_core", continuous_conduction, 2'b01);
    go(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
    wait_lvl(8'h8C, 8'h00, 9000);
    tick(5);
    chk("off", {nb_rail_good_out, continuous_conduction}, 3'b101);
    chk("drops", drops, 0);
    watch = 1'b0;
    protection_fault_in <= 2'b01;
    go(1'b1, 1'b0, 8'hA4, 1'b1, 1'b1);
    tick(200);
    go(1'b1, 1'b0, 8'h88, 1'b1, 1'b1);
    wait_lvl(8'h88, 8'h00, 3000);
    tick(20);
    chk("retarget", core_ref_level, 8'h88);
    chk("prot", core_rail_good_out, 1'b0);
    protection_fault_in <= 2'b00;
    system_power_good_in <= 1'b0;
    tick(6);
    chk("tel_hi", {telemetry_out, continuous_conduction}, 3'b111);
    go(1'b1, 1'b1, 8'hA8, 1'b0, 1'b0);
    wait_lvl(8'h90, 8'h90, 32000);
    tick(200);
    chk("boot_back", {core_ref_level, northbridge_ref_level}, 16'h9090);
    system_power_good_in <= 1'b1;
    tick(300);
    chk("hold", core_ref_level, 8'h90);
    go(1'b1, 1'b0, 8'h98, 1'b1, 1'b1);
    wait_lvl(8'h98, 8'h90, 2000);
    chk("resume", core_ref_level, 8'h98);
    conclude();
  end
endmodule
